// file: design/return_reset_option_ops.v
// Purpose: executes no-op, option load, software reset and both returns.
// Assumes: one fetched instruction offered per instruction cycle when ready.
// Notes: other opcodes only advance the program counter here.
`timescale 1ns/10ps
`default_nettype none
`include "core_ops_map.vh"
module return_reset_option_ops #(
	parameter AW = 15
)(
	// Clock and reset.
	input  wire          clock,
	input  wire          rst_n,
	// Instruction stream.
	input  wire          instr_valid,
	input  wire [13:0]   instr,
	output wire          instr_ready,
	// Call side of the stack.
	input  wire          call_push,
	input  wire [AW-1:0] call_addr,
	// Working register.
	input  wire [7:0]    w_value,
	// Core state.
	output reg  [AW-1:0] pc_q,
	output reg  [7:0]    option_q,
	output reg  [7:0]    interrupt_control_register_q,
	output reg  [7:0]    power_control_register_q,
	output reg           device_reset_q
);
	////////////////////////////////////////////////////////////////////////
	// One-hot states: RUN takes instructions, WAIT is the second cycle of a return.
	localparam S_RUN  = 2'b01;
	localparam S_WAIT = 2'b10;

	////////////////////////////////////////////////////////////////////////
	// Registers and their next values.
	reg  [1:0]    state_q;
	reg  [1:0]    state_d;
	reg  [AW-1:0] pc_d;
	reg  [7:0]    option_d;
	reg  [7:0]    interrupt_control_d;
	reg  [7:0]    power_control_d;
	reg           device_reset_d;
	reg  [AW-1:0] ret_addr_q;
	reg  [AW-1:0] ret_addr_d;
	wire [AW-1:0] top_of_stack;

	////////////////////////////////////////////////////////////////////////
	// Instruction decode. Nothing is taken in the second cycle of a return
	// nor while the soft reset pulse is high.
	wire          take        = instr_valid && state_q == S_RUN && !device_reset_q;
	wire          is_opt_load = take && instr == `OP_OPTION_LOAD;
	wire          is_soft_rst = take && instr == `OP_SOFT_RESET;
	wire          is_rint     = take && instr == `OP_RET_INT;
	wire          is_rsub     = take && instr == `OP_RET_SUB;
	wire          do_pop      = is_rint || is_rsub;
	wire          advance     = take && !is_soft_rst && !do_pop;

	assign instr_ready = state_q == S_RUN && !device_reset_q;

	// A call push that meets a pop is dropped, so the pointer moves one way only.
	return_stack #(
		.DEPTH (`STACK_DEPTH),
		.PW    (`STACK_PTR_W),
		.AW    (AW)
	) u_stack (
		.clock     (clock),
		.rst_n     (rst_n),
		.push      (call_push && !do_pop),
		.push_data (call_addr),
		.pop       (do_pop),
		.top_q     (top_of_stack)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic. Every register holds unless a taken instruction or
	// the soft reset pulse changes it.
	always @*
	begin
		state_d             = state_q;
		pc_d                = pc_q;
		option_d            = option_q;
		interrupt_control_d = interrupt_control_register_q;
		power_control_d     = power_control_register_q;
		device_reset_d      = 1'b0;
		ret_addr_d          = ret_addr_q;
		if (device_reset_q)
		begin
			// The pulse resets the sequencer, program counter, option and interrupt control as a hardware reset would.
			state_d             = S_RUN;
			pc_d                = `PC_RESET;
			option_d            = `OPTION_RESET;
			interrupt_control_d = `INTERRUPT_CONTROL_RESET;
		end
		else
		begin
			case (state_q)
				S_RUN:
				begin
					if (is_soft_rst)
					begin
						device_reset_d = 1'b1;
						power_control_d[`RESET_INSTRUCTION_FLAG_BIT] = 1'b0;
					end
					if (do_pop)
					begin
						// The popped address is kept here: one edge later the stack's top
						// register already shows the entry below it.
						ret_addr_d = top_of_stack;
						state_d    = S_WAIT;
					end
					if (is_rint)
						interrupt_control_d[`GLOBAL_INTERRUPT_ENABLE_BIT] = 1'b1;
					if (advance)
						pc_d = pc_q + {{(AW-1){1'b0}}, 1'b1};
					if (is_opt_load)
						option_d = w_value;
				end
				S_WAIT:
				begin
					pc_d    = ret_addr_q;
					state_d = S_RUN;
				end
				default:
					state_d = S_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers, all loaded with their reset values by the asynchronous reset.

	// Sequencer state. WAIT lasts exactly one cycle, so a return spends two
	// instruction cycles and the next fetch is refused for one of them.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_RUN;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Program counter. Returns load it in their second cycle.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pc_q <= `PC_RESET;
		end
		else
		begin
			pc_q <= pc_d;
		end
	end

	// Option register. Only the option load and the resets write it.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			option_q <= `OPTION_RESET;
		end
		else
		begin
			option_q <= option_d;
		end
	end

	// Interrupt control. Instructions write only the global enable bit; the resets load the whole register.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			interrupt_control_register_q <= `INTERRUPT_CONTROL_RESET;
		end
		else
		begin
			interrupt_control_register_q <= interrupt_control_d;
		end
	end

	// Power control. The soft reset leaves it alone so that the cleared
	// reset-instruction flag survives and reports the cause of the reset.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_control_register_q <= `POWER_CONTROL_RESET;
		end
		else
		begin
			power_control_register_q <= power_control_d;
		end
	end

	// Soft reset pulse, high for one cycle.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			device_reset_q <= 1'b0;
		end
		else
		begin
			device_reset_q <= device_reset_d;
		end
	end

	// Return address, captured when a return is taken.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ret_addr_q <= {AW{1'b0}};
		end
		else
		begin
			ret_addr_q <= ret_addr_d;
		end
	end
endmodule // return_reset_option_ops
`default_nettype wire

// file: design/core_ops_map.vh
// Purpose: constants for the return, reset and option instruction executor.
// Assumes: 14-bit instruction words, 15-bit program counter.
// Notes: encodings follow the core's opcode map.
`ifndef CORE_OPS_MAP_VH
`define CORE_OPS_MAP_VH

`define OP_NOP          14'h0000
`define OP_OPTION_LOAD  14'h0062
`define OP_SOFT_RESET   14'h0001
`define OP_RET_INT      14'h0009
`define OP_RET_SUB      14'h0008

`define GLOBAL_INTERRUPT_ENABLE_BIT  7
`define RESET_INSTRUCTION_FLAG_BIT   2
`define OPTION_RESET                 8'hff
`define INTERRUPT_CONTROL_RESET      8'h00
`define POWER_CONTROL_RESET          8'h1c
`define PC_RESET        15'h0000
`define STACK_DEPTH     16
`define STACK_PTR_W     4

`endif

// file: design/return_stack.v
// Purpose: hardware return stack, register-read top of stack.
// Assumes: push and pop are never requested together.
// Notes: wraps on overflow and underflow.
`timescale 1ns/10ps
`default_nettype none
module return_stack #(
	parameter DEPTH = 16,
	parameter PW    = 4,
	parameter AW    = 15
)(
	// Clock and reset.
	input  wire          clock,
	input  wire          rst_n,
	// Stack operations.
	input  wire          push,
	input  wire [AW-1:0] push_data,
	input  wire          pop,
	output reg  [AW-1:0] top_q
);
	reg [AW-1:0] mem [0:DEPTH-1];
	reg [PW-1:0] ptr_q;
	wire [PW-1:0] ptr_dn = ptr_q - {{(PW-1){1'b0}}, 1'b1};

	always @(posedge clock)
	begin
		if (push)
			mem[ptr_q] <= push_data;
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ptr_q <= {PW{1'b0}};
			top_q <= {AW{1'b0}};
		end
		else if (push)
		begin
			ptr_q <= ptr_q + {{(PW-1){1'b0}}, 1'b1};
			top_q <= push_data;
		end
		else if (pop)
		begin
			ptr_q <= ptr_dn;
			top_q <= mem[ptr_dn - {{(PW-1){1'b0}}, 1'b1}];
		end
	end
endmodule // return_stack
`default_nettype wire

// file: verification/ops_checker_assertions.sv
// Purpose: timing checks of the return, reset and option executor.
// Assumes: bound to return_reset_option_ops.
// Notes: return targets are checked by the bench.
`timescale 1ns/10ps
`default_nettype none
module ops_checker(
	input wire logic        clock, rst_n, instr_valid, instr_ready, device_reset_q,
	input wire logic [13:0] instr,
	input wire logic [14:0] pc_q,
	input wire logic [7:0]  w_value, option_q, interrupt_control_register_q, power_control_register_q
);
	wire logic tk = instr_valid && instr_ready;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_two; !instr_ready ##1 instr_ready; endsequence
	a_opt_load: assert property (tk && instr == 14'h0062 |=>
		option_q == $past(w_value) && $stable(interrupt_control_register_q)) else $error("option load");
	a_opt_time: assert property (tk && instr == 14'h0062 |=>
		instr_ready && pc_q == $past(pc_q) + 15'h1) else $error("option time");
	a_rst_flag: assert property (tk && instr == 14'h0001 |=>
		device_reset_q && !power_control_register_q[2]) else $error("reset flag");
	a_rst_state: assert property (device_reset_q |-> !instr_ready ##1
		pc_q == 15'h0 && option_q == 8'hff && interrupt_control_register_q == 8'h00) else $error("reset state");
	a_ret_enable: assert property (tk && instr == 14'h0009 |=>
		interrupt_control_register_q[7]) else $error("interrupt enable");
	a_ret_time: assert property (tk && instr == 14'h0009 |=> s_two) else $error("int return time");
	a_sub_time: assert property (tk && instr == 14'h0008 |=>
		s_two ##0 $stable(interrupt_control_register_q)) else $error("sub return time");
	a_nop_pc: assert property (tk && instr == 14'h0000 |=>
		pc_q == $past(pc_q) + 15'h1 && $stable(option_q)) else $error("no-op");
endmodule // ops_checker
bind return_reset_option_ops ops_checker u_chk(.clock, .rst_n, .instr_valid, .instr_ready,
	.device_reset_q, .instr, .pc_q, .w_value, .option_q, .interrupt_control_register_q,
	.power_control_register_q);
`default_nettype wire

// file: verification/testbench.sv
// Purpose: self-checking bench of the return, reset and option executor.
// Assumes: state settles one cycle after a take, two for returns and the soft reset.
// Notes: random data comes from an LFSR.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clock = 0, rst_n = 0, instr_valid = 0, call_push = 0, chk = 0, g = 0, rflag = 1;
	logic [13:0] instr = 0;
	logic [14:0] call_addr = 0, pc_q, pc = 0, a, b;
	logic [7:0]  w_value = 0, option_q, interrupt_control_register_q, power_control_register_q, opt = 8'hff;
	logic        instr_ready, device_reset_q;
	logic [24:0] q[$];
	logic [31:0] s = 32'he5a6;
	int          num_errors = 0, num_checks = 0, cyc = 0;
	wire logic [24:0] seen_state = {pc_q, option_q, interrupt_control_register_q[7], power_control_register_q[2]};
	return_reset_option_ops u_dut(.clock, .rst_n, .instr_valid, .instr, .instr_ready, .call_push,
		.call_addr, .w_value, .pc_q, .option_q, .interrupt_control_register_q, .power_control_register_q,
		.device_reset_q);
	initial forever #10 clock = ~clock;
	function logic [31:0] nx(input logic [31:0] v);
		nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task check(input logic [24:0] seen, input logic [24:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error state expected %h seen %h", exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task op(input logic [13:0] c, input int n);
		@(posedge clock);
		instr <= c;
		w_value <= s[7:0];
		instr_valid <= 1;
		@(posedge clock);
		instr_valid <= 0;
		repeat (n - 1) @(posedge clock);
		q.push_back({pc, opt, g, rflag});
		chk <= 1;
		@(posedge clock);
		chk <= 0;
	endtask
	task push(input logic [14:0] v);
		@(posedge clock);
		call_push <= 1;
		call_addr <= v;
		@(posedge clock);
		call_push <= 0;
	endtask
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			stop_test;
		end
		else if (chk)
			check(seen_state, q.pop_front());
	end
	initial
	begin
		repeat (8) @(posedge clock);
		rst_n <= 1;
		for (int i = 0; i < 4; i++)
		begin
			s = nx(s);
			pc++;
			op(14'h0000, 1);
			s = nx(s);
			pc++;
			opt = s[7:0];
			op(14'h0062, 1);
		end
		$display("one-cycle ops done");
		s = nx(s);
		a = s[14:0];
		s = nx(s);
		b = s[14:0];
		push(a);
		push(b);
		pc = b;
		g = 1;
		op(14'h0009, 2);
		pc = a;
		op(14'h0008, 2);
		$display("returns done");
		pc = 0;
		opt = 8'hff;
		g = 0;
		rflag = 0;
		op(14'h0001, 2);
		@(posedge clock);
		$display("soft reset done");
		stop_test;
	end
endmodule // testbench
`default_nettype wire
